// [abc_board_ctrl.sv]
// Purpose: board global control and gpio level registers of a two-channel adc mezzanine
// Assumes: plain register port with byte enables; read data one cycle after the read strobe
// Notes:   control word at 0x8100 lanes 1:0, gpio level at 0x8102 lanes 3:2
`timescale 1ns/100ps

module abc_board_ctrl
#(
    parameter int AW          = abc_pkg::ADDR_W,
    parameter int DW          = abc_pkg::DATA_W,
    parameter int SW          = abc_pkg::SAMPLE_W,
    parameter int NCH         = abc_pkg::NUM_CHAN,
    parameter int SETTLE_CYC  = abc_pkg::AMP_SETTLE_CYC
)
(
    input  wire logic                 ref_clk,
    input  wire logic                 resetn,
    input  wire logic [AW-1:0]        reg_addr,
    input  wire logic [DW-1:0]        reg_wdata,
    input  wire logic [DW/8-1:0]      reg_be,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [DW-1:0]        reg_rdata,
    input  wire logic                 gpio_in,
    output logic                      gpio_out,
    output logic                      gpio_oe,
    input  wire logic                 pll_clk2,
    output logic                      clk_src_ext,
    output logic                      base_clk_en,
    output logic      [NCH-1:0]       amp_pwr_en,
    output logic      [NCH-1:0]       amp_settled,
    input  wire logic [NCH-1:0]       sample_valid,
    input  wire logic [NCH*SW-1:0]    sample_data,
    input  wire logic [NCH-1:0]       fifo_full,
    output logic      [NCH-1:0]       fifo_wr_en,
    output logic      [NCH*SW-1:0]    fifo_wr_data,
    output logic      [NCH-1:0]       sample_dropped
);

    // ****************************************************************
    // address decode
    // ****************************************************************
    // both registers live in one aligned word; byte lanes pick which
    wire logic        word_hit  = (reg_addr[AW-1:abc_pkg::WORD_LSB] ==
                                   abc_pkg::CTRL_ADDR[AW-1:abc_pkg::WORD_LSB]);
    wire logic        wr_hit    = reg_wr & word_hit;
    wire logic        rd_hit    = reg_rd & word_hit;

    // ****************************************************************
    // byte lane masks
    // ****************************************************************
    wire logic [15:0] ctrl_lane = {{8{reg_be[1]}}, {8{reg_be[0]}}};
    wire logic [15:0] gpio_lane = {{8{reg_be[3]}}, {8{reg_be[2]}}};
    wire logic [15:0] ctrl_wd   = reg_wdata[15:0];
    wire logic [15:0] gpio_wd   = reg_wdata[31:16];

    // ****************************************************************
    // control register
    // ****************************************************************
    logic      [15:0] ctrl_reg;
    logic      [15:0] ctrl_next;
    logic             gpio_out_reg;
    logic             gpio_out_next;

    wire logic [15:0] ctrl_merge = (ctrl_reg & ~ctrl_lane) | (ctrl_wd & ctrl_lane);

    // unimplemented bits never store anything
    assign ctrl_next = wr_hit ? (ctrl_merge & abc_pkg::CTRL_WMASK) : ctrl_reg;

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_reg <= abc_pkg::CTRL_RESET;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
        end
    end

    // ****************************************************************
    // control field decode
    // ****************************************************************
    wire logic [1:0]     gpio_mode  = ctrl_reg[abc_pkg::GPIO_MODE_MSB:abc_pkg::GPIO_MODE_LSB];
    wire logic [1:0]     clk_src    = ctrl_reg[abc_pkg::CLK_SRC_MSB:abc_pkg::CLK_SRC_LSB];
    // unused codes fall back to the crystal, the safe source
    wire logic           ext_sel    = (clk_src == abc_pkg::CLK_SRC_EXT);
    // both enables come from the same flop word, so one write moves both
    wire logic [NCH-1:0] store_en   = ctrl_reg[abc_pkg::STORE_EN_LSB +: NCH];
    wire logic [NCH-1:0] amp_req    = ctrl_reg[abc_pkg::AMP_PWR_LSB +: NCH];
    wire logic           base_clk   = ctrl_reg[abc_pkg::BASE_CLK_BIT];
    wire logic           mode_out   = (gpio_mode == abc_pkg::ABC_GPIO_OUT);

    // ****************************************************************
    // gpio level register
    // ****************************************************************
    wire logic gpio_lvl_we = wr_hit & gpio_lane[abc_pkg::GPIO_LEVEL_BIT];

    // the written level is kept in any mode, but reaches the pin only in output mode
    assign gpio_out_next = gpio_lvl_we ? gpio_wd[abc_pkg::GPIO_LEVEL_BIT] : gpio_out_reg;

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            gpio_out_reg <= abc_pkg::GPIO_OUT_RESET;
        end
        else
        begin
            gpio_out_reg <= gpio_out_next;
        end
    end

    // ****************************************************************
    // gpio pad
    // ****************************************************************
    logic gpio_level;

    abc_gpio_pad u_gpio_pad
    (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .mode      (gpio_mode),
        .out_level (gpio_out_reg),
        .pll_clk2  (pll_clk2),
        .pin_in    (gpio_in),
        .pin_out   (gpio_out),
        .pin_oe    (gpio_oe),
        .pin_level (gpio_level)
    );

    // ****************************************************************
    // read path
    // ****************************************************************
    // input and clock modes show the pin, output mode shows the driven value
    wire logic        gpio_rd_bit = mode_out ? gpio_out_reg : gpio_level;
    wire logic [15:0] gpio_rd16   = {15'h0000, gpio_rd_bit} & abc_pkg::GPIO_WMASK;
    wire logic [15:0] ctrl_rd16   = ctrl_reg & abc_pkg::CTRL_WMASK;
    wire logic [31:0] rd_word     = {gpio_rd16, ctrl_rd16};
    // lanes not enabled read zero so narrow reads never leak a neighbour
    wire logic [31:0] rd_lane     = {{8{reg_be[3]}}, {8{reg_be[2]}}, {8{reg_be[1]}}, {8{reg_be[0]}}};
    wire logic [31:0] rd_next     = rd_hit ? (rd_word & rd_lane) : abc_pkg::RD_ZERO;

    logic [DW-1:0] rdata_reg;

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata_reg <= abc_pkg::RD_ZERO;
        end
        else
        begin
            rdata_reg <= rd_next;
        end
    end

    assign reg_rdata = rdata_reg;

    // ****************************************************************
    // clock and power outputs
    // ****************************************************************
    logic           clk_src_ext_reg;
    logic           base_clk_en_reg;
    logic [NCH-1:0] amp_pwr_reg;

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            clk_src_ext_reg <= 1'b0;
            base_clk_en_reg <= 1'b0;
            amp_pwr_reg     <= '0;
        end
        else
        begin
            clk_src_ext_reg <= ext_sel;
            base_clk_en_reg <= base_clk;
            amp_pwr_reg     <= amp_req;
        end
    end

    assign clk_src_ext = clk_src_ext_reg;
    assign base_clk_en = base_clk_en_reg;
    assign amp_pwr_en  = amp_pwr_reg;

    // ****************************************************************
    // amplifier settling and per-channel storage
    // ****************************************************************
    localparam logic [abc_pkg::SETTLE_CNT_W-1:0] SETTLE_LAST =
        abc_pkg::SETTLE_CNT_W'(SETTLE_CYC - 1);

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch = ch + 1)
        begin : g_chan
            logic [abc_pkg::SETTLE_CNT_W-1:0] settle_cnt_reg;
            logic [abc_pkg::SETTLE_CNT_W-1:0] settle_cnt_next;
            logic                             settled_reg;

            // counts from power-up of the buffer; a power-down restarts it
            wire logic cnt_done = (settle_cnt_reg == SETTLE_LAST);
            assign settle_cnt_next = !amp_pwr_reg[ch] ? '0 :
                                     cnt_done         ? settle_cnt_reg :
                                     settle_cnt_reg + 1'b1;

            always_ff @(posedge ref_clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    settle_cnt_reg <= '0;
                    settled_reg    <= 1'b0;
                end
                else
                begin
                    settle_cnt_reg <= settle_cnt_next;
                    settled_reg    <= amp_pwr_reg[ch] & cnt_done;
                end
            end

            assign amp_settled[ch] = settled_reg;

            abc_store_chan #(.DW(SW)) u_store
            (
                .ref_clk      (ref_clk),
                .resetn       (resetn),
                .store_en     (store_en[ch]),
                .sample_valid (sample_valid[ch]),
                .sample_data  (sample_data[ch*SW +: SW]),
                .fifo_full    (fifo_full[ch]),
                .wr_en        (fifo_wr_en[ch]),
                .wr_data      (fifo_wr_data[ch*SW +: SW]),
                .dropped      (sample_dropped[ch])
            );
        end
    endgenerate

endmodule

// [abc_pkg.sv]
// Purpose: shared constants for the board control and gpio register bank
// Assumes: 32-bit plain register port, byte addressed, 250 MHz ref_clk
// Notes:   both 16-bit registers share one aligned word

// ****************************************************************
// package
// ****************************************************************
package abc_pkg;

    localparam int          ADDR_W          = 21;
    localparam int          DATA_W          = 32;
    localparam int          BE_W            = 4;
    localparam int          REG_W           = 16;
    localparam int          SAMPLE_W        = 16;
    localparam int          NUM_CHAN        = 2;

    // register byte addresses
    localparam logic [20:0] CTRL_ADDR       = 21'h00_8100;
    localparam logic [20:0] GPIO_ADDR       = 21'h00_8102;
    localparam int          WORD_LSB        = 2;

    // control and gpio field positions
    localparam int          GPIO_MODE_LSB   = 0;
    localparam int          GPIO_MODE_MSB   = 1;
    localparam int          CLK_SRC_LSB     = 3;
    localparam int          CLK_SRC_MSB     = 4;
    localparam int          STORE_EN_LSB    = 5;
    localparam int          AMP_PWR_LSB     = 8;
    localparam int          BASE_CLK_BIT    = 10;
    localparam int          GPIO_LEVEL_BIT  = 0;

    // implemented bits; all others read zero
    localparam logic [15:0] CTRL_WMASK      = 16'h077B;
    localparam logic [15:0] GPIO_WMASK      = 16'h0001;
    localparam logic [15:0] CTRL_RESET      = 16'h0000;
    localparam logic        GPIO_OUT_RESET  = 1'b0;
    localparam logic [31:0] RD_ZERO         = 32'h0000_0000;

    typedef enum logic [1:0]
    {
        ABC_GPIO_IN     = 2'b00,
        ABC_GPIO_OUT    = 2'b01,
        ABC_GPIO_PLL2   = 2'b10,
        ABC_GPIO_UNUSED = 2'b11
    } abc_gpio_mode_t;

    localparam logic [1:0]  CLK_SRC_XTAL    = 2'b00;
    localparam logic [1:0]  CLK_SRC_EXT     = 2'b10;

    // amplifier settling time
    localparam int          CLK_PERIOD_PS   = 4000;
    localparam int          AMP_SETTLE_US   = 10;
    localparam int          AMP_SETTLE_CYC  = (AMP_SETTLE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          SETTLE_CNT_W    = 12;

endpackage

// [abc_store_chan.sv]
// Purpose: one channel of sample storage towards its fifo or sram
// Assumes: sample_valid pulses once per adc clock period, synchronous to ref_clk
// Notes:   conversion keeps running; only the write is gated
`timescale 1ns/100ps

module abc_store_chan
#(
    parameter int DW = 16
)
(
    input  wire logic          ref_clk,
    input  wire logic          resetn,
    input  wire logic          store_en,
    input  wire logic          sample_valid,
    input  wire logic [DW-1:0] sample_data,
    input  wire logic          fifo_full,
    output logic               wr_en,
    output logic [DW-1:0]      wr_data,
    output logic               dropped
);

    // ****************************************************************
    // write gating
    // ****************************************************************
    wire logic take_sample = store_en & sample_valid & ~fifo_full;
    wire logic lose_sample = store_en & sample_valid & fifo_full;

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_en   <= 1'b0;
            wr_data <= '0;
            dropped <= 1'b0;
        end
        else
        begin
            wr_en   <= take_sample;
            dropped <= lose_sample;
            if (take_sample)
            begin
                wr_data <= sample_data;
            end
        end
    end

endmodule

// [abc_gpio_pad.sv]
// Purpose: gpio pin driver and sampler, selected by the gpio function field
// Assumes: pin input and pll clock 2 are synchronous to ref_clk
// Notes:   pll clock 2 passes through one flop, so it is limited to ref_clk/2
`timescale 1ns/100ps

module abc_gpio_pad
(
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic [1:0] mode,
    input  wire logic       out_level,
    input  wire logic       pll_clk2,
    input  wire logic       pin_in,
    output logic            pin_out,
    output logic            pin_oe,
    output logic            pin_level
);

    // ****************************************************************
    // mode decode
    // ****************************************************************
    wire logic drive_level = (mode == abc_pkg::ABC_GPIO_OUT);
    wire logic drive_clock = (mode == abc_pkg::ABC_GPIO_PLL2);
    wire logic out_next    = drive_clock ? pll_clk2 : out_level;

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pin_out   <= 1'b0;
            pin_oe    <= 1'b0;
            // idle pull-up level until the first sample
            pin_level <= 1'b1;
        end
        else
        begin
            pin_out   <= out_next;
            pin_oe    <= drive_level | drive_clock;
            pin_level <= pin_in;
        end
    end

endmodule

// [abc_chk.sv]
// Purpose: port-level checks of the board control register bank
// Assumes: default channel count and sample width
// Notes:   one clock domain, so default clocking and disable are shared
`timescale 1ns/100ps

// ********
// checker
// ********
module abc_chk
(
    input wire logic        ref_clk,
    input wire logic        resetn,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        gpio_oe,
    input wire logic        clk_src_ext,
    input wire logic        base_clk_en,
    input wire logic [1:0]  amp_pwr_en,
    input wire logic [1:0]  sample_valid,
    input wire logic [31:0] sample_data,
    input wire logic [1:0]  fifo_full,
    input wire logic [1:0]  fifo_wr_en,
    input wire logic [31:0] fifo_wr_data,
    input wire logic [1:0]  sample_dropped
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    chk_rd_slot: assert property (
        reg_rdata != 32'h0000_0000 |-> $past(reg_rd))
        else $error("read data outside its slot");
    chk_unused_zero: assert property (
        (reg_rdata & 32'hFFFE_F884) == 32'h0000_0000)
        else $error("unused bit read as one");
    chk_store_one: assert property (
        fifo_wr_en[0] |-> $past(sample_valid[0] && !fifo_full[0])
                          && fifo_wr_data[15:0] == $past(sample_data[15:0]))
        else $error("channel one store without a sample");
    chk_store_two: assert property (
        fifo_wr_en[1] |-> $past(sample_valid[1] && !fifo_full[1])
                          && fifo_wr_data[31:16] == $past(sample_data[31:16]))
        else $error("channel two store without a sample");
    chk_full_drop: assert property (
        sample_dropped[0] |-> $past(fifo_full[0] && sample_valid[0]) && !fifo_wr_en[0])
        else $error("drop without a full fifo");
    chk_src_write: assert property (
        $changed(clk_src_ext) |-> $past(reg_wr, 2))
        else $error("clock source moved without a write");
    chk_pwr_write: assert property (
        $changed(base_clk_en) || $changed(amp_pwr_en) |-> $past(reg_wr, 2))
        else $error("power or clock enable moved without a write");
    // register flop then pad flop: same two-edge latency as the other outputs
    chk_dir_write: assert property (
        $changed(gpio_oe) |-> $past(reg_wr, 2))
        else $error("pin direction moved without a write");
endmodule

bind abc_board_ctrl abc_chk i_chk
(
    .ref_clk(ref_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .gpio_oe(gpio_oe), .clk_src_ext(clk_src_ext), .base_clk_en(base_clk_en), .amp_pwr_en(amp_pwr_en),
    .sample_valid(sample_valid), .sample_data(sample_data), .fifo_full(fifo_full), .fifo_wr_en(fifo_wr_en),
    .fifo_wr_data(fifo_wr_data), .sample_dropped(sample_dropped)
);

// [abc_far_model.sv]
// Purpose: far side: shared adc sample source, two fifo fill counters, gpio pin
// Assumes: both channels convert on one adc clock
// Notes:   data changes every cycle, so only strobed samples carry meaning
`timescale 1ns/100ps

// ********
// model
// ********
module abc_far_model
#(
    parameter int DEPTH = 8,
    parameter int DIV   = 4
)
(
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic [1:0] fifo_wr_en,
    input  wire logic       drain,
    input  wire logic       gpio_out,
    input  wire logic       gpio_oe,
    input  wire logic       ext_en,
    input  wire logic       ext_lvl,
    output logic      [1:0] sample_valid,
    output logic     [31:0] sample_data,
    output logic      [1:0] fifo_full,
    output logic            gpio_pin,
    output logic      [7:0] fill0,
    output logic      [7:0] fill1
);
    logic [3:0]  div_reg;
    logic [15:0] seq_reg;

    // conversion runs whatever the amplifier power bits say
    assign sample_valid = {2{div_reg == 4'h0}};
    assign sample_data  = {~seq_reg, seq_reg};
    assign fifo_full    = {fill1 == 8'(DEPTH), fill0 == 8'(DEPTH)};
    // undriven pin floats high through the pull-up
    assign gpio_pin     = gpio_oe ? gpio_out : (ext_en ? ext_lvl : 1'b1);

    // no overflow guard: a write into a full fifo shows as an overfill
    always_ff @(posedge ref_clk or negedge resetn)
        if (!resetn)
            {div_reg, seq_reg, fill0, fill1} <= '0;
        else
        begin
            div_reg <= (div_reg == 4'(DIV - 1)) ? 4'h0 : div_reg + 4'h1;
            seq_reg <= seq_reg + 16'h0001;
            fill0   <= drain ? 8'h00 : fill0 + 8'(fifo_wr_en[0]);
            fill1   <= drain ? 8'h00 : fill1 + 8'(fifo_wr_en[1]);
        end
endmodule

// [tb.sv]
// Purpose: self-checking bench for the board control register bank
// Assumes: short settle count; far-side model supplies samples and the pin
// Notes:   each scenario judges its own results
`timescale 1ns/100ps

`define CHK(nm, got, ex) \
    begin \
        samples_checked++; \
        if ((got) !== (ex)) \
        begin \
            err_count++; \
            $display("Error %s expected %0h seen %0h", nm, ex, got); \
        end \
    end

// ********
// bench
// ********
module tb;
    localparam int          SETTLE = 4;
    localparam logic [20:0] C = abc_pkg::CTRL_ADDR;
    localparam logic [20:0] G = abc_pkg::GPIO_ADDR;
    int          err_count;
    int          samples_checked;
    logic        ref_clk, resetn, reg_wr, reg_rd, pll_clk2, drain, ext_en, ext_lvl, gpio_pin;
    logic        gpio_out, gpio_oe, clk_src_ext, base_clk_en;
    logic [1:0]  amp_pwr_en, amp_settled, sample_valid, fifo_full, fifo_wr_en, sample_dropped;
    logic [3:0]  reg_be;
    logic [7:0]  fill0, fill1;
    logic [20:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, sample_data, fifo_wr_data, d;

    abc_board_ctrl #(.SETTLE_CYC(SETTLE)) i_dut
    (
        .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_be(reg_be),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpio_in(gpio_pin), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .pll_clk2(pll_clk2), .clk_src_ext(clk_src_ext), .base_clk_en(base_clk_en),
        .amp_pwr_en(amp_pwr_en), .amp_settled(amp_settled), .sample_valid(sample_valid),
        .sample_data(sample_data), .fifo_full(fifo_full), .fifo_wr_en(fifo_wr_en),
        .fifo_wr_data(fifo_wr_data), .sample_dropped(sample_dropped)
    );
    abc_far_model i_far
    (
        .ref_clk(ref_clk), .resetn(resetn), .fifo_wr_en(fifo_wr_en), .drain(drain), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .ext_en(ext_en), .ext_lvl(ext_lvl), .sample_valid(sample_valid),
        .sample_data(sample_data), .fifo_full(fifo_full), .gpio_pin(gpio_pin), .fill0(fill0), .fill1(fill1)
    );

    always #2 ref_clk = ~ref_clk;

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wr(input logic [20:0] a, input logic [31:0] v, input logic [3:0] be);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_be    <= be;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [20:0] a, input logic [3:0] be);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_be   <= be;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic dr;
        @(posedge ref_clk) drain <= 1'b1;
        @(posedge ref_clk) drain <= 1'b0;
    endtask

    task automatic complete_run;
        if (err_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic t_reset;
        `CHK("outputs", {clk_src_ext, base_clk_en, amp_pwr_en, gpio_oe, fifo_wr_en}, 7'h00)
        rd(C, 4'hF);
        `CHK("reset word", d, 32'h0001_0000)
    endtask

    task automatic t_fields;
        wr(C, 32'h0000_FFFF, 4'h3);
        rd(C, 4'hF);
        `CHK("ctrl mask", d, 32'h0001_077B)
        `CHK("clk out", base_clk_en, 1'b1)
        `CHK("amp pwr", {amp_pwr_en, amp_settled}, 4'hC)
        cyc(SETTLE + 4);
        `CHK("amp settled", amp_settled, 2'h3)
        for (int i = 0; i < 4; i++)
        begin
            wr(C, 32'(i * 9), 4'h1);
            cyc(3);
            `CHK("clk src", clk_src_ext, 1'(i == 2))
            `CHK("gpio dir", gpio_oe, 1'(i % 3 != 0))
        end
    endtask

    task automatic t_lanes;
        wr(C + 21'h00_0001, 32'h0000_0500, 4'h2);
        rd(C + 21'h00_0001, 4'h2);
        `CHK("byte read", d, 32'h0000_0500)
        rd(G, 4'hC);
        `CHK("half read", d, 32'h0001_0000)
        wr(21'h00_8104, 32'hFFFF_FFFF, 4'hF);
        rd(21'h00_8104, 4'hF);
        `CHK("unmapped", d, 32'h0000_0000)
        rd(C, 4'hF);
        `CHK("word read", {amp_pwr_en, d}, {2'h1, 32'h0001_051B})
    endtask

    task automatic t_gpio;
        for (int v = 0; v < 2; v++)
        begin
            wr(C, 32'h0000_0000, 4'h1);
            @(posedge ref_clk) {ext_en, ext_lvl} <= {1'b1, 1'(v)};
            rd(G, 4'h4);
            `CHK("pin in", d, 32'(v) << 16)
            wr(C, 32'h0000_0001, 4'h1);
            // unused gpio bits written as ones must still read zero
            wr(G, 32'hFFFE_0000 | (32'(v) << 16), 4'h4);
            rd(G, 4'h4);
            `CHK("pin out", {gpio_oe, gpio_out, d}, {1'b1, 1'(v), 32'(v) << 16})
        end
        wr(C, 32'h0000_0002, 4'h1);
        @(posedge ref_clk) pll_clk2 <= 1'b1;
        cyc(4);
        `CHK("pll high", {gpio_oe, gpio_out}, 2'h3)
        @(posedge ref_clk) pll_clk2 <= 1'b0;
        cyc(3);
        // held output level is one here, so only the clock path gives zero
        `CHK("pll low", {gpio_oe, gpio_out}, 2'h2)
        @(posedge ref_clk) ext_en <= 1'b0;
    endtask

    task automatic t_store;
        logic skew;
        logic drop;
        skew = 1'b0;
        drop = 1'b0;
        dr();
        wr(C, 32'h0000_0060, 4'h1);
        // long enough to fill both fifos and then hit them while full
        for (int n = 0; n < 100; n++)
        begin
            cyc(1);
            skew |= (fifo_wr_en[0] ^ fifo_wr_en[1]) | (sample_dropped[0] ^ sample_dropped[1]);
            drop |= &sample_dropped;
        end
        `CHK("store skew", skew, 1'b0)
        `CHK("drop seen", drop, 1'b1)
        `CHK("full fill", {fill1, fill0}, 16'h0808)
        wr(C, 32'h0000_0020, 4'h1);
        dr();
        cyc(60);
        `CHK("ch1 only", {fill1, fill0}, 16'h0008)
        wr(C, 32'h0000_0000, 4'h1);
        dr();
        cyc(40);
        `CHK("stopped", {fill1, fill0}, 16'h0000)
    endtask

    initial
    begin
        {ref_clk, resetn, reg_wr, reg_rd, pll_clk2, drain, ext_en, ext_lvl} = 8'h00;
        {reg_addr, reg_wdata, reg_be} = '0;
        err_count = 0;
        samples_checked = 0;
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        t_reset();
        t_fields();
        t_lanes();
        t_gpio();
        t_store();
        complete_run();
    end
endmodule
